// [ofd_map.svh]
// register offsets, field positions and fixed codes of the operand field decoder
// assumes: included by bare name from the decoder module; 8-bit byte address, 32-bit data
`ifndef OFD_MAP_SVH
`define OFD_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFD_ADDR_CTRL    8'h00
`define OFD_ADDR_FIELD   8'h04
`define OFD_ADDR_WORD    8'h08
`define OFD_ADDR_RESULT  8'h0C
`define OFD_ADDR_EXT     8'h10
`define OFD_ADDR_IMM     8'h14
`define OFD_ADDR_STAT    8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OFD_CTRL_KIND    4:0
`define OFD_CTRL_SRC     5
`define OFD_CTRL_DUAL    6
`define OFD_FIELD_VAL    6:0
`define OFD_WORD_VAL     15:0
`define OFD_RES_RID      5:0
`define OFD_RES_LEGAL    8
`define OFD_RES_WIDTH    11:9
`define OFD_RES_SIGNED   12
`define OFD_STAT_ILLEGAL 0

// ----------------------------------------------------------------
// fixed codes
// ----------------------------------------------------------------
`define OFD_FULL_LONG_CODE 5'h0C
`define OFD_MOVE_AGU_BAD   3'h7
`define OFD_ZERO_HALF      16'h0000

`endif

// [ofd_pkg.sv]
// types of the operand field decoder: field kinds, physical registers, widths, state
// assumes: compiled before the decoder module
package ofd_pkg;

	typedef enum logic [4:0] {
		OFD_K_PTR_FULL, OFD_K_MOVE_AGU, OFD_K_MOVE_AGU_ALT, OFD_K_PTR_LOW, OFD_K_SEC_INDEX,
		OFD_K_ALU_MAIN, OFD_K_ALU_UPPER, OFD_K_ALU_NO_LONG, OFD_K_ACC_OR_LONG, OFD_K_ACC_SET,
		OFD_K_DATA_WORD_SET, OFD_K_ACC_AB, OFD_K_AB_UPPER, OFD_K_FULL_MOVE, OFD_K_CD_PART,
		OFD_K_STACK_MISC, OFD_K_STACK_SPECIAL, OFD_K_AGU_EXTRA, OFD_K_BR_DISP7, OFD_K_BR_TOP2,
		OFD_K_BR_TOP3, OFD_K_OFF_PTR2, OFD_K_OFF_STACK, OFD_K_IMM5, OFD_K_IMM6, OFD_K_IMM7
	} ofd_kind_e;

	typedef enum logic [5:0] {
		OFD_R_PTR0, OFD_R_PTR1, OFD_R_PTR2, OFD_R_PTR3, OFD_R_PTR4, OFD_R_PTR5,
		OFD_R_INDEX, OFD_R_STACK_POINTER, OFD_R_SEC_INDEX, OFD_R_MODULO_MOD, OFD_R_FAST_IRQ_RET,
		OFD_R_ACC_A, OFD_R_ACC_A_EXT, OFD_R_ACC_A_HI, OFD_R_ACC_A_LO,
		OFD_R_ACC_B, OFD_R_ACC_B_EXT, OFD_R_ACC_B_HI, OFD_R_ACC_B_LO,
		OFD_R_ACC_C, OFD_R_ACC_C_EXT, OFD_R_ACC_C_HI, OFD_R_ACC_C_LO,
		OFD_R_ACC_D, OFD_R_ACC_D_EXT, OFD_R_ACC_D_HI, OFD_R_ACC_D_LO,
		OFD_R_LONG, OFD_R_LONG_HIGH_WORD, OFD_R_LONG_LOW_WORD, OFD_R_INPUT_WORD_ZERO,
		OFD_R_OPER_MODE, OFD_R_STATUS, OFD_R_LOOP_ADDR, OFD_R_LOOP_ADDR2,
		OFD_R_LOOP_COUNT, OFD_R_LOOP_COUNT2, OFD_R_HW_STACK, OFD_R_NONE
	} ofd_reg_e;

	typedef enum logic [2:0] {OFD_W_NONE, OFD_W16, OFD_W24, OFD_W32, OFD_W36} ofd_width_e;

	typedef struct packed {
		ofd_reg_e    rid;
		logic        legal;
		logic [15:0] imm;
	} ofd_dec_s;

	typedef struct packed {
		ofd_kind_e   kind;
		logic        src;
		logic        dual;
		logic [6:0]  fld;
		logic [15:0] word;
		ofd_reg_e    rid;
		logic        legal;
		ofd_width_e  width;
		logic        sgn;
		logic [31:0] ext;
		logic [15:0] imm;
		logic        sticky;
		logic [31:0] rdata;
	} ofd_state_s;

endpackage : ofd_pkg

// [ofd_decoder.sv]
// operand register field decoder: maps an instruction field of a given kind onto a
// physical register, its width and word-write extension, or onto an extended immediate
// assumes: one 20 MHz clock, bus master on the same clock, no wait states
`timescale 1ns/1ps
`include "ofd_map.svh"

module ofd_decoder
	import ofd_pkg::*;
(
	input  wire logic        CLK_SYS,
	input  wire logic        SYS_RST,
	input  wire logic [7:0]  BUS_ADDR,
	input  wire logic [31:0] BUS_WDATA,
	input  wire logic        BUS_WR,
	input  wire logic        BUS_RD,
	output logic      [31:0] BUS_RDATA,
	output logic             DEC_ILLEGAL
);

	// ----------------------------------------------------------------
	// lookup tables, index is the raw field code
	// ----------------------------------------------------------------
	localparam ofd_reg_e PTR_FULL_TBL [0:7] = '{OFD_R_PTR0, OFD_R_PTR1, OFD_R_PTR2, OFD_R_PTR3,
		OFD_R_PTR4, OFD_R_PTR5, OFD_R_INDEX, OFD_R_STACK_POINTER};
	localparam ofd_reg_e ALU_MAIN_TBL [0:7] = '{OFD_R_ACC_A, OFD_R_ACC_B, OFD_R_ACC_C, OFD_R_ACC_D,
		OFD_R_LONG, OFD_R_INPUT_WORD_ZERO, OFD_R_LONG_LOW_WORD, OFD_R_LONG_HIGH_WORD};
	localparam ofd_reg_e ALU_UPPER_TBL [0:7] = '{OFD_R_ACC_A_HI, OFD_R_ACC_B_HI, OFD_R_ACC_C_HI,
		OFD_R_ACC_D_HI, OFD_R_INPUT_WORD_ZERO, OFD_R_LONG_LOW_WORD, OFD_R_LONG_HIGH_WORD, OFD_R_NONE};
	localparam ofd_reg_e NO_LONG_TBL [0:7] = '{OFD_R_ACC_A, OFD_R_ACC_B, OFD_R_ACC_C, OFD_R_ACC_D,
		OFD_R_INPUT_WORD_ZERO, OFD_R_LONG_LOW_WORD, OFD_R_LONG_HIGH_WORD, OFD_R_NONE};
	localparam ofd_reg_e ACC_LONG_TBL [0:7] = '{OFD_R_ACC_A, OFD_R_ACC_B, OFD_R_ACC_C, OFD_R_ACC_D,
		OFD_R_LONG, OFD_R_NONE, OFD_R_NONE, OFD_R_NONE};
	localparam ofd_reg_e DATA_WORD_TBL [0:3] = '{OFD_R_INPUT_WORD_ZERO, OFD_R_LONG_LOW_WORD,
		OFD_R_LONG_HIGH_WORD, OFD_R_NONE};
	localparam ofd_reg_e CD_PART_TBL [0:3] = '{OFD_R_ACC_C_EXT, OFD_R_ACC_D_EXT, OFD_R_ACC_C_LO,
		OFD_R_ACC_D_LO};
	// codes 0..15 are the signed-write subset, 16..30 the unsigned-write subset
	localparam ofd_reg_e FULL_TBL [0:31] = '{
		OFD_R_ACC_A, OFD_R_ACC_A_EXT, OFD_R_ACC_A_HI, OFD_R_ACC_A_LO,
		OFD_R_ACC_B, OFD_R_ACC_B_EXT, OFD_R_ACC_B_HI, OFD_R_ACC_B_LO,
		OFD_R_ACC_C, OFD_R_ACC_C_HI, OFD_R_ACC_D, OFD_R_ACC_D_HI,
		OFD_R_LONG, OFD_R_LONG_HIGH_WORD, OFD_R_LONG_LOW_WORD, OFD_R_INPUT_WORD_ZERO,
		OFD_R_PTR0, OFD_R_PTR1, OFD_R_PTR2, OFD_R_PTR3,
		OFD_R_PTR4, OFD_R_PTR5, OFD_R_INDEX, OFD_R_STACK_POINTER,
		OFD_R_MODULO_MOD, OFD_R_SEC_INDEX, OFD_R_OPER_MODE, OFD_R_STATUS,
		OFD_R_LOOP_ADDR, OFD_R_LOOP_COUNT, OFD_R_HW_STACK, OFD_R_NONE};
	localparam ofd_reg_e STACK_TBL [0:31] = '{
		OFD_R_ACC_A_EXT, OFD_R_ACC_B_EXT, OFD_R_ACC_C_EXT, OFD_R_ACC_D_EXT,
		OFD_R_LONG_LOW_WORD, OFD_R_LONG_HIGH_WORD, OFD_R_INPUT_WORD_ZERO, OFD_R_STACK_POINTER,
		OFD_R_MODULO_MOD, OFD_R_SEC_INDEX, OFD_R_LOOP_ADDR, OFD_R_LOOP_ADDR2,
		OFD_R_LOOP_COUNT, OFD_R_LOOP_COUNT2, OFD_R_HW_STACK, OFD_R_OPER_MODE,
		OFD_R_STATUS, OFD_R_NONE, OFD_R_NONE, OFD_R_NONE,
		OFD_R_NONE, OFD_R_NONE, OFD_R_NONE, OFD_R_NONE,
		OFD_R_NONE, OFD_R_NONE, OFD_R_NONE, OFD_R_NONE,
		OFD_R_NONE, OFD_R_NONE, OFD_R_NONE, OFD_R_NONE};

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	function automatic ofd_dec_s ofd_decode(input ofd_kind_e k, input logic [6:0] f,
		input logic src, input logic dual);
		ofd_dec_s d;
		d.rid   = OFD_R_NONE;
		d.imm   = 16'h0000;
		d.legal = 1'b0;
		case (k)
			OFD_K_PTR_FULL:       d.rid = PTR_FULL_TBL[f[2:0]];
			OFD_K_MOVE_AGU,
			OFD_K_MOVE_AGU_ALT:   d.rid = (f[2:0] == `OFD_MOVE_AGU_BAD) ? OFD_R_NONE
				: PTR_FULL_TBL[f[2:0]];
			OFD_K_PTR_LOW:        d.rid = PTR_FULL_TBL[{1'b0, f[1:0]}];
			OFD_K_SEC_INDEX:      d.rid = dual ? OFD_R_SEC_INDEX : OFD_R_NONE;
			OFD_K_ALU_MAIN:       d.rid = ALU_MAIN_TBL[f[2:0]];
			OFD_K_ALU_UPPER:      d.rid = ALU_UPPER_TBL[f[2:0]];
			OFD_K_ALU_NO_LONG:    d.rid = NO_LONG_TBL[f[2:0]];
			OFD_K_ACC_OR_LONG:    d.rid = ACC_LONG_TBL[f[2:0]];
			OFD_K_ACC_SET:        d.rid = ALU_MAIN_TBL[{1'b0, f[1:0]}];
			OFD_K_DATA_WORD_SET:  d.rid = DATA_WORD_TBL[f[1:0]];
			OFD_K_ACC_AB:         d.rid = f[0] ? OFD_R_ACC_B : OFD_R_ACC_A;
			OFD_K_AB_UPPER: begin
				// only meaningful as a parallel-move source
				if (src) begin
					d.rid = f[0] ? OFD_R_ACC_B_HI : OFD_R_ACC_A_HI;
				end
			end
			OFD_K_FULL_MOVE: begin
				// the long register has no source path in this field
				if (!(src && f[4:0] == `OFD_FULL_LONG_CODE)) begin
					d.rid = FULL_TBL[f[4:0]];
				end
			end
			OFD_K_CD_PART:        d.rid = CD_PART_TBL[f[1:0]];
			OFD_K_STACK_MISC:     d.rid = STACK_TBL[f[4:0]];
			OFD_K_STACK_SPECIAL:  d.rid = STACK_TBL[{1'b0, f[3:0]}];
			OFD_K_AGU_EXTRA:      d.rid = f[0] ? OFD_R_FAST_IRQ_RET : OFD_R_MODULO_MOD;
			OFD_K_BR_DISP7:       d.imm = {{9{f[6]}}, f[6:0]};
			OFD_K_BR_TOP2:        d.imm = {14'h0000, f[1:0]};
			OFD_K_BR_TOP3:        d.imm = {13'h0000, f[2:0]};
			OFD_K_OFF_PTR2: begin
				d.rid = OFD_R_PTR2;
				d.imm = {10'h000, f[5:0]};
			end
			OFD_K_OFF_STACK: begin
				d.rid = OFD_R_STACK_POINTER;
				d.imm = 16'h0000 - {10'h000, f[5:0]};
			end
			OFD_K_IMM5:           d.imm = {{11{f[4]}}, f[4:0]};
			OFD_K_IMM6:           d.imm = {{10{f[5]}}, f[5:0]};
			OFD_K_IMM7:           d.imm = {{9{f[6]}}, f[6:0]};
			default:              d.rid = OFD_R_NONE;
		endcase
		// immediate-only kinds carry no register yet are legal
		case (k)
			OFD_K_BR_DISP7, OFD_K_BR_TOP2, OFD_K_BR_TOP3,
			OFD_K_IMM5, OFD_K_IMM6, OFD_K_IMM7: d.legal = 1'b1;
			default:                            d.legal = (d.rid != OFD_R_NONE);
		endcase
		return d;
	endfunction : ofd_decode

	function automatic ofd_width_e ofd_width(input ofd_reg_e r);
		case (r)
			OFD_R_ACC_A, OFD_R_ACC_B, OFD_R_ACC_C, OFD_R_ACC_D:   return OFD_W36;
			OFD_R_LONG:                                           return OFD_W32;
			OFD_R_PTR0, OFD_R_PTR1, OFD_R_PTR2, OFD_R_PTR3, OFD_R_PTR4, OFD_R_PTR5,
			OFD_R_INDEX, OFD_R_STACK_POINTER, OFD_R_SEC_INDEX:    return OFD_W24;
			OFD_R_NONE:                                           return OFD_W_NONE;
			default:                                              return OFD_W16;
		endcase
	endfunction : ofd_width

	// data-alu registers take sign extension on a word write except the long register, which takes the word in its high half; all others zero extension
	function automatic logic ofd_signed_write(input ofd_reg_e r);
		return (r >= OFD_R_ACC_A) && (r <= OFD_R_INPUT_WORD_ZERO);
	endfunction : ofd_signed_write

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ofd_state_s state_reg;
	ofd_state_s state_next;
	ofd_dec_s   dec;

	always_comb begin
		state_next = state_reg;
		dec        = ofd_decode(state_reg.kind, state_reg.fld, state_reg.src, state_reg.dual);

		// decode stage: inputs registered last cycle give results this cycle
		state_next.rid   = dec.rid;
		state_next.legal = dec.legal;
		state_next.imm   = dec.imm;
		state_next.width = ofd_width(dec.rid);
		state_next.sgn   = ofd_signed_write(dec.rid);
		if (!dec.legal || dec.rid == OFD_R_NONE) begin
			state_next.ext = 32'h0000_0000;
		end else if (dec.rid == OFD_R_LONG) begin
			state_next.ext = {state_reg.word, `OFD_ZERO_HALF};
		end else if (ofd_signed_write(dec.rid)) begin
			state_next.ext = {{16{state_reg.word[15]}}, state_reg.word};
		end else begin
			state_next.ext = {16'h0000, state_reg.word};
		end

		// register writes
		if (BUS_WR) begin
			case (BUS_ADDR)
				`OFD_ADDR_CTRL: begin
					state_next.kind = ofd_kind_e'(BUS_WDATA[`OFD_CTRL_KIND]);
					state_next.src  = BUS_WDATA[`OFD_CTRL_SRC];
					state_next.dual = BUS_WDATA[`OFD_CTRL_DUAL];
				end
				`OFD_ADDR_FIELD: state_next.fld  = BUS_WDATA[`OFD_FIELD_VAL];
				`OFD_ADDR_WORD:  state_next.word = BUS_WDATA[`OFD_WORD_VAL];
				`OFD_ADDR_STAT: begin
					if (BUS_WDATA[`OFD_STAT_ILLEGAL]) begin
						state_next.sticky = 1'b0;
					end
				end
				default: state_next.sticky = state_next.sticky;
			endcase
		end
		// an illegal result standing in the result register beats a clear in the same cycle
		if (state_reg.legal == 1'b0 && state_reg.width == OFD_W_NONE && state_reg.rid == OFD_R_NONE) begin
			state_next.sticky = 1'b1;
		end

		// read data stand only in the cycle after the strobe
		state_next.rdata = 32'h0000_0000;
		if (BUS_RD) begin
			case (BUS_ADDR)
				`OFD_ADDR_CTRL:   state_next.rdata = {25'h0, state_reg.dual, state_reg.src, state_reg.kind};
				`OFD_ADDR_FIELD:  state_next.rdata = {25'h0, state_reg.fld};
				`OFD_ADDR_WORD:   state_next.rdata = {16'h0000, state_reg.word};
				`OFD_ADDR_RESULT: state_next.rdata = {19'h0, state_reg.sgn, state_reg.width,
					state_reg.legal, 2'h0, state_reg.rid};
				`OFD_ADDR_EXT:    state_next.rdata = state_reg.ext;
				`OFD_ADDR_IMM:    state_next.rdata = {16'h0000, state_reg.imm};
				`OFD_ADDR_STAT:   state_next.rdata = {31'h0, state_reg.sticky};
				default:          state_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	// reset leaves kind 0 with field 0, whose first decode is a legal pointer
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign BUS_RDATA   = state_reg.rdata;
	assign DEC_ILLEGAL = ~state_reg.legal;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (SYS_RST);

	property p_ptr_full;
		state_reg.kind == OFD_K_PTR_FULL |=> state_reg.legal
			&& state_reg.rid == PTR_FULL_TBL[$past(state_reg.fld[2:0])];
	endproperty
	a_ptr_full: assert property (p_ptr_full) else $error("pointer field decode wrong");

	property p_move_agu;
		state_reg.kind == OFD_K_MOVE_AGU && state_reg.fld[2:0] == `OFD_MOVE_AGU_BAD |=> !state_reg.legal;
	endproperty
	a_move_agu: assert property (p_move_agu) else $error("move agu code 7 accepted");

	property p_ptr_low;
		state_reg.kind == OFD_K_PTR_LOW |=> state_reg.rid inside {OFD_R_PTR0, OFD_R_PTR1, OFD_R_PTR2, OFD_R_PTR3};
	endproperty
	a_ptr_low: assert property (p_ptr_low) else $error("low pointer field out of set");

	property p_sec_index;
		state_reg.kind == OFD_K_SEC_INDEX |=> state_reg.legal == $past(state_reg.dual);
	endproperty
	a_sec_index: assert property (p_sec_index) else $error("secondary index legality wrong");

	property p_alu_width;
		state_reg.kind == OFD_K_ALU_MAIN |=> state_reg.width == ($past(state_reg.fld[2]) ?
			($past(state_reg.fld[1:0]) == 2'h0 ? OFD_W32 : OFD_W16) : OFD_W36);
	endproperty
	a_alu_width: assert property (p_alu_width) else $error("main alu width wrong");

	property p_no_long;
		state_reg.kind inside {OFD_K_ALU_NO_LONG, OFD_K_ALU_UPPER} |=> state_reg.rid != OFD_R_LONG;
	endproperty
	a_no_long: assert property (p_no_long) else $error("long register decoded");

	// the pin is checked in the same cycle as the result, since the next field may already be legal
	property p_long_src;
		state_reg.kind == OFD_K_FULL_MOVE && state_reg.src && state_reg.fld[4:0] == `OFD_FULL_LONG_CODE
			|=> !state_reg.legal && DEC_ILLEGAL;
	endproperty
	a_long_src: assert property (p_long_src) else $error("long register accepted as source");

	property p_long_word;
		state_reg.legal && state_reg.rid == OFD_R_LONG |->
			state_reg.ext == {$past(state_reg.word), `OFD_ZERO_HALF};
	endproperty
	a_long_word: assert property (p_long_word) else $error("long word write not cleared");

	property p_sign_ext;
		state_reg.legal && state_reg.sgn && state_reg.rid != OFD_R_LONG |->
			state_reg.ext == {{16{$past(state_reg.word[15])}}, $past(state_reg.word)};
	endproperty
	a_sign_ext: assert property (p_sign_ext) else $error("signed word write wrong");

	property p_zero_ext;
		state_reg.legal && !state_reg.sgn |-> state_reg.ext[31:16] == 16'h0000;
	endproperty
	a_zero_ext: assert property (p_zero_ext) else $error("unsigned word write extended");

	property p_imm5;
		state_reg.kind == OFD_K_IMM5 |=> state_reg.imm == {{11{$past(state_reg.fld[4])}}, $past(state_reg.fld[4:0])};
	endproperty
	a_imm5: assert property (p_imm5) else $error("five-bit immediate wrong");

	property p_stack_off;
		state_reg.kind == OFD_K_OFF_STACK |=> state_reg.rid == OFD_R_STACK_POINTER
			&& state_reg.imm + {10'h000, $past(state_reg.fld[5:0])} == 16'h0000;
	endproperty
	a_stack_off: assert property (p_stack_off) else $error("stack offset wrong");

	property p_sticky;
		!state_reg.legal && state_reg.rid == OFD_R_NONE && state_reg.width == OFD_W_NONE |=> state_reg.sticky;
	endproperty
	a_sticky: assert property (p_sticky) else $error("illegal decode not latched");

	property p_alu_upper;
		state_reg.kind == OFD_K_ALU_UPPER && state_reg.fld[2:0] != 3'h7 |=> state_reg.legal
			&& state_reg.rid inside {OFD_R_ACC_A_HI, OFD_R_ACC_B_HI, OFD_R_ACC_C_HI, OFD_R_ACC_D_HI,
			OFD_R_INPUT_WORD_ZERO, OFD_R_LONG_LOW_WORD, OFD_R_LONG_HIGH_WORD};
	endproperty
	a_alu_upper: assert property (p_alu_upper) else $error("upper word field out of set");

	property p_acc_long;
		state_reg.kind == OFD_K_ACC_OR_LONG |=> state_reg.rid inside {OFD_R_ACC_A, OFD_R_ACC_B,
			OFD_R_ACC_C, OFD_R_ACC_D, OFD_R_LONG, OFD_R_NONE};
	endproperty
	a_acc_long: assert property (p_acc_long) else $error("accumulator or long field out of set");

	property p_acc_set;
		state_reg.kind == OFD_K_ACC_SET |=> state_reg.legal && state_reg.width == OFD_W36;
	endproperty
	a_acc_set: assert property (p_acc_set) else $error("accumulator field not an accumulator");

	property p_data_word;
		state_reg.kind == OFD_K_DATA_WORD_SET |=> state_reg.rid inside {OFD_R_INPUT_WORD_ZERO,
			OFD_R_LONG_LOW_WORD, OFD_R_LONG_HIGH_WORD, OFD_R_NONE};
	endproperty
	a_data_word: assert property (p_data_word) else $error("data word field out of set");

	property p_acc_ab;
		state_reg.kind == OFD_K_ACC_AB |=>
			state_reg.rid == ($past(state_reg.fld[0]) ? OFD_R_ACC_B : OFD_R_ACC_A);
	endproperty
	a_acc_ab: assert property (p_acc_ab) else $error("single-bit accumulator wrong");

	property p_ab_upper;
		state_reg.kind == OFD_K_AB_UPPER && !state_reg.src |=> !state_reg.legal;
	endproperty
	a_ab_upper: assert property (p_ab_upper) else $error("upper word source used as destination");

	property p_cd_part;
		state_reg.kind == OFD_K_FULL_MOVE |=> !(state_reg.rid inside {OFD_R_ACC_C_EXT, OFD_R_ACC_C_LO,
			OFD_R_ACC_D_EXT, OFD_R_ACC_D_LO});
	endproperty
	a_cd_part: assert property (p_cd_part) else $error("c or d part reached by full move");

	property p_br_disp7;
		state_reg.kind == OFD_K_BR_DISP7 |=> state_reg.legal
			&& state_reg.imm == {{9{$past(state_reg.fld[6])}}, $past(state_reg.fld[6:0])};
	endproperty
	a_br_disp7: assert property (p_br_disp7) else $error("branch displacement wrong");

	property p_stack_special;
		state_reg.kind == OFD_K_STACK_SPECIAL |=> state_reg.legal;
	endproperty
	a_stack_special: assert property (p_stack_special) else $error("special stack code refused");

	property p_agu_extra;
		state_reg.kind == OFD_K_AGU_EXTRA |=> state_reg.rid inside {OFD_R_MODULO_MOD, OFD_R_FAST_IRQ_RET};
	endproperty
	a_agu_extra: assert property (p_agu_extra) else $error("extra agu register wrong");

	c_long_dst:   cover property (state_reg.legal && state_reg.rid == OFD_R_LONG);
	c_illegal:    cover property (state_reg.kind == OFD_K_FULL_MOVE && DEC_ILLEGAL);
	c_cd_part:    cover property (state_reg.legal && state_reg.rid == OFD_R_ACC_D_LO);
	c_read_after: cover property (BUS_RD && BUS_ADDR == `OFD_ADDR_RESULT ##1 BUS_RDATA != 32'h0);
	c_set_wins:   cover property (BUS_WR && BUS_ADDR == `OFD_ADDR_STAT && !state_reg.legal
		&& state_reg.rid == OFD_R_NONE ##1 state_reg.sticky);

endmodule : ofd_decoder

// [ofd_host_model.sv]
// ofd_host_model: register bus master standing in for fetch and register file logic
// assumes: one clock shared with the decoder, read data one cycle after the strobe
`timescale 1ns/1ps
module ofd_host_model (
	input  wire logic        clk_sys,
	output logic      [7:0]  bus_addr,
	output logic      [31:0] bus_wdata,
	output logic             bus_wr,
	output logic             bus_rd,
	input  wire logic [31:0] bus_rdata
);
	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	initial begin
		bus_addr  = 8'h00;
		bus_wdata = 32'h00000000;
		bus_wr    = 1'b0;
		bus_rd    = 1'b0;
	end
	// an idle edge before each strobe, so no signal is set twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge clk_sys);
		bus_wr    <= 1'b0;
		bus_addr  <= ~a;
		bus_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge clk_sys);
		bus_rd   <= 1'b0;
		bus_addr <= ~a;
		@(posedge clk_sys);
		d = bus_rdata;
	endtask : rd
endmodule : ofd_host_model

// [tb_top.sv]
// tb_top: self-checking bench of the operand field decoder
// assumes: the host model is the only bus master, one 20 MHz clock
`timescale 1ns/1ps
`include "ofd_map.svh"
module tb_top
	import ofd_pkg::*;
;
	localparam logic [15:0] W  = 16'h8001;
	localparam logic [31:0] ZX = 32'h00008001;
	localparam logic [31:0] SX = 32'hFFFF8001;
	localparam logic [31:0] LX = 32'h80010000;
	// marks an extension image left unchecked
	localparam logic [31:0] DC = 32'h5A5A5A5A;
	logic        CLK_SYS;
	logic        SYS_RST;
	logic [7:0]  BUS_ADDR;
	logic [31:0] BUS_WDATA;
	logic        BUS_WR;
	logic        BUS_RD;
	logic [31:0] BUS_RDATA;
	logic        DEC_ILLEGAL;
	int          failures;
	int          n_compared;
	logic [31:0] rv;

	ofd_decoder u_ofd_decoder (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .BUS_ADDR(BUS_ADDR),
		.BUS_WDATA(BUS_WDATA), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA),
		.DEC_ILLEGAL(DEC_ILLEGAL));
	ofd_host_model u_ofd_host_model (.clk_sys(CLK_SYS), .bus_addr(BUS_ADDR), .bus_wdata(BUS_WDATA),
		.bus_wr(BUS_WR), .bus_rd(BUS_RD), .bus_rdata(BUS_RDATA));

	initial begin
		CLK_SYS = 1'b0;
		forever #25 CLK_SYS = ~CLK_SYS;
	end

	// ----------------------------------------------------------------
	// shared checks
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic run(input logic [4:0] k, input logic [1:0] p, input logic [6:0] f, input logic [5:0] rid,
		input logic lg, input logic [2:0] wd, input logic sg, input logic [31:0] ex, input logic [15:0] im);
		logic [31:0] m;
		m = 32'hFFFFFFFF;
		u_ofd_host_model.wr(`OFD_ADDR_CTRL, {25'h0000000, p, k});
		u_ofd_host_model.wr(`OFD_ADDR_FIELD, {25'h0000000, f});
		u_ofd_host_model.wr(`OFD_ADDR_WORD, {16'h0000, W});
		// one edge stores, one decodes
		repeat (2) @(posedge CLK_SYS);
		u_ofd_host_model.rd(`OFD_ADDR_RESULT, rv);
		if (rid == 6'h3F) m[5:0] = 6'h00;
		if (wd == 3'h7) m[11:9] = 3'h0;
		if (k > 5'h11) m[12:9] = 4'h0;
		cmp("result", {19'h00000, sg, wd, lg, 2'h0, rid} & m, rv & m);
		cmp("illegal pin", {31'h00000000, ~lg}, {31'h00000000, DEC_ILLEGAL});
		u_ofd_host_model.rd(`OFD_ADDR_EXT, rv);
		if (ex != DC) cmp("ext", ex, rv);
		u_ofd_host_model.rd(`OFD_ADDR_IMM, rv);
		if (k > 5'h11 && lg) cmp("imm", {16'h0000, im}, rv);
		u_ofd_host_model.rd(`OFD_ADDR_CTRL, rv);
		cmp("ctrl", {25'h0000000, p, k}, rv);
		u_ofd_host_model.rd(`OFD_ADDR_FIELD, rv);
		cmp("field", {25'h0000000, f}, rv);
		u_ofd_host_model.rd(`OFD_ADDR_WORD, rv);
		cmp("word", {16'h0000, W}, rv);
	endtask : run
	task automatic c(input logic [4:0] k, input logic [1:0] p, input logic [6:0] f, input logic [5:0] rid,
		input logic [2:0] wd, input logic sg, input logic [31:0] ex);
		run(k, p, f, rid, 1'b1, wd, sg, ex, 16'h0000);
	endtask : c
	task automatic bad(input logic [4:0] k, input logic [1:0] p, input logic [6:0] f);
		run(k, p, f, OFD_R_NONE, 1'b0, OFD_W_NONE, 1'b0, 32'h00000000, 16'h0000);
	endtask : bad
	task automatic ci(input logic [4:0] k, input logic [6:0] f, input logic [5:0] rid, input logic [15:0] im);
		run(k, 2'h0, f, rid, 1'b1, 3'h7, 1'b0, DC, im);
	endtask : ci

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		repeat (5) @(posedge CLK_SYS);
		#1;
		cmp("rdata in reset", 32'h00000000, BUS_RDATA);
		cmp("illegal in reset", 32'h00000001, {31'h00000000, DEC_ILLEGAL});
		repeat (5) @(posedge CLK_SYS);
		SYS_RST <= 1'b0;
		repeat (2) @(posedge CLK_SYS);
		u_ofd_host_model.rd(`OFD_ADDR_RESULT, rv);
		cmp("result after reset", 32'h00000500, rv);
		u_ofd_host_model.rd(`OFD_ADDR_STAT, rv);
		cmp("sticky after reset", 32'h00000000, rv);
	endtask : t_reset
	task automatic t_agu();
		c(OFD_K_PTR_FULL, 2'h0, 7'h07, OFD_R_STACK_POINTER, OFD_W24, 1'b0, ZX);
		c(OFD_K_MOVE_AGU_ALT, 2'h0, 7'h06, OFD_R_INDEX, OFD_W24, 1'b0, ZX);
		bad(OFD_K_MOVE_AGU, 2'h0, 7'h07);
		c(OFD_K_PTR_LOW, 2'h0, 7'h03, OFD_R_PTR3, OFD_W24, 1'b0, ZX);
		c(OFD_K_SEC_INDEX, 2'h2, 7'h00, OFD_R_SEC_INDEX, OFD_W24, 1'b0, ZX);
		bad(OFD_K_SEC_INDEX, 2'h0, 7'h00);
		c(OFD_K_AGU_EXTRA, 2'h0, 7'h00, OFD_R_MODULO_MOD, 3'h7, 1'b0, ZX);
		c(OFD_K_AGU_EXTRA, 2'h0, 7'h01, OFD_R_FAST_IRQ_RET, 3'h7, 1'b0, ZX);
	endtask : t_agu
	task automatic t_alu();
		c(OFD_K_ALU_MAIN, 2'h0, 7'h04, OFD_R_LONG, OFD_W32, 1'b1, LX);
		c(OFD_K_ALU_MAIN, 2'h0, 7'h05, OFD_R_INPUT_WORD_ZERO, OFD_W16, 1'b1, SX);
		c(OFD_K_ALU_UPPER, 2'h0, 7'h00, OFD_R_ACC_A_HI, OFD_W16, 1'b1, SX);
		bad(OFD_K_ALU_UPPER, 2'h0, 7'h07);
		c(OFD_K_ALU_NO_LONG, 2'h0, 7'h04, OFD_R_INPUT_WORD_ZERO, OFD_W16, 1'b1, SX);
		bad(OFD_K_ALU_NO_LONG, 2'h0, 7'h07);
		c(OFD_K_ACC_OR_LONG, 2'h0, 7'h04, OFD_R_LONG, OFD_W32, 1'b1, LX);
		bad(OFD_K_ACC_OR_LONG, 2'h0, 7'h05);
		c(OFD_K_ACC_SET, 2'h0, 7'h03, OFD_R_ACC_D, OFD_W36, 1'b1, SX);
		c(OFD_K_DATA_WORD_SET, 2'h0, 7'h02, OFD_R_LONG_HIGH_WORD, OFD_W16, 1'b1, SX);
		bad(OFD_K_DATA_WORD_SET, 2'h0, 7'h03);
		c(OFD_K_ACC_AB, 2'h0, 7'h01, OFD_R_ACC_B, OFD_W36, 1'b1, SX);
	endtask : t_alu
	task automatic t_move();
		c(OFD_K_AB_UPPER, 2'h1, 7'h01, OFD_R_ACC_B_HI, OFD_W16, 1'b1, SX);
		bad(OFD_K_AB_UPPER, 2'h0, 7'h01);
		c(OFD_K_FULL_MOVE, 2'h0, 7'h0C, OFD_R_LONG, OFD_W32, 1'b1, LX);
		bad(OFD_K_FULL_MOVE, 2'h1, 7'h0C);
		c(OFD_K_FULL_MOVE, 2'h0, 7'h1B, OFD_R_STATUS, 3'h7, 1'b0, ZX);
		c(OFD_K_FULL_MOVE, 2'h0, 7'h09, OFD_R_ACC_C_HI, OFD_W16, 1'b1, SX);
		c(OFD_K_CD_PART, 2'h0, 7'h03, OFD_R_ACC_D_LO, 3'h7, 1'b1, SX);
	endtask : t_move
	task automatic t_stack();
		c(OFD_K_STACK_MISC, 2'h0, 7'h10, OFD_R_STATUS, 3'h7, 1'b0, ZX);
		bad(OFD_K_STACK_MISC, 2'h0, 7'h11);
		c(OFD_K_STACK_SPECIAL, 2'h0, 7'h07, OFD_R_STACK_POINTER, 3'h7, 1'b0, ZX);
	endtask : t_stack
	task automatic t_imm();
		ci(OFD_K_BR_DISP7, 7'h40, OFD_R_NONE, 16'hFFC0);
		ci(OFD_K_BR_TOP2, 7'h7F, OFD_R_NONE, 16'h0003);
		ci(OFD_K_BR_TOP3, 7'h05, OFD_R_NONE, 16'h0005);
		ci(OFD_K_OFF_PTR2, 7'h3F, OFD_R_PTR2, 16'h003F);
		ci(OFD_K_OFF_STACK, 7'h05, OFD_R_STACK_POINTER, 16'hFFFB);
		ci(OFD_K_IMM5, 7'h10, OFD_R_NONE, 16'hFFF0);
		ci(OFD_K_IMM6, 7'h1F, OFD_R_NONE, 16'h001F);
		ci(OFD_K_IMM7, 7'h40, OFD_R_NONE, 16'hFFC0);
	endtask : t_imm
	task automatic t_regs();
		bad(5'h1A, 2'h0, 7'h00);
		u_ofd_host_model.rd(`OFD_ADDR_STAT, rv);
		cmp("sticky set", 32'h00000001, rv);
		// the illegal result still stands, so the set beats this clear
		u_ofd_host_model.wr(`OFD_ADDR_STAT, 32'h00000001);
		u_ofd_host_model.rd(`OFD_ADDR_STAT, rv);
		cmp("sticky kept", 32'h00000001, rv);
		@(posedge CLK_SYS);
		cmp("rdata after read", 32'h00000000, BUS_RDATA);
		c(OFD_K_PTR_FULL, 2'h0, 7'h00, OFD_R_PTR0, OFD_W24, 1'b0, ZX);
		u_ofd_host_model.wr(`OFD_ADDR_STAT, 32'h00000001);
		u_ofd_host_model.rd(`OFD_ADDR_STAT, rv);
		cmp("sticky cleared", 32'h00000000, rv);
		u_ofd_host_model.wr(8'h1C, 32'hFFFFFFFF);
		u_ofd_host_model.rd(8'h1C, rv);
		cmp("unmapped read", 32'h00000000, rv);
	endtask : t_regs

	initial begin
		SYS_RST    = 1'b1;
		failures   = 0;
		n_compared = 0;
		t_reset();
		t_agu();
		t_alu();
		t_move();
		t_stack();
		t_imm();
		t_regs();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		failures++;
		report_and_stop();
	end
endmodule : tb_top
